/* bus_side_model.sv */
`timescale 1ns/10ps
// Processor status, address decoder and frequency sources around the generator
module bus_side_model (
	// Clocks and wire levels
	input  wire logic       clk_in,
	input  wire logic       sys_clk_in,
	// Bench commands
	input  wire logic       go_in,
	input  wire logic [1:0] mode_in,
	input  wire logic [3:0] delay_in,
	// Source clocks
	output logic            crystal_a_out,
	output logic            ext_freq_out,
	// Status and ready pins
	output logic            status_low_n_out,
	output logic            status_high_n_out,
	output logic            async_n_out,
	output logic            async_en_n_out,
	output logic            sync_n_out,
	output logic            sync_en_n_out,
	output logic            in_status_out
);
	logic [3:0] xt_cnt_ff   = 4'h0;  // Crystal half-period count
	logic [3:0] ef_cnt_ff   = 4'h0;  // External half-period count
	logic [3:0] fall_cnt_ff = 4'h0;  // System clock falls seen in a phase
	logic [1:0] state_ff    = 2'h0;  // Idle, status, delay, ready
	logic       sys_q_ff    = 1'b0;  // Last system clock level
	wire        sys_fall    = sys_q_ff & ~sys_clk_in;
	initial begin
		{crystal_a_out, ext_freq_out, in_status_out} = 3'h0;
		{status_low_n_out, status_high_n_out} = 2'h3;
		{async_n_out, async_en_n_out, sync_n_out, sync_en_n_out} = 4'hF;
	end
	// Sources kept slow so no edge is lost: crystal 10 MCLK, external 12 MCLK
	always @(posedge clk_in) begin
		xt_cnt_ff <= (xt_cnt_ff == 4'h4) ? 4'h0 : xt_cnt_ff + 4'h1;
		ef_cnt_ff <= (ef_cnt_ff == 4'h5) ? 4'h0 : ef_cnt_ff + 4'h1;
		if (xt_cnt_ff == 4'h4)
			crystal_a_out <= ~crystal_a_out;
		if (ef_cnt_ff == 4'h5)
			ext_freq_out <= ~ext_freq_out;
	end
	// Bus cycle: status low for four falls, a delay of falls, then one ready pair
	always @(posedge clk_in) begin
		sys_q_ff <= sys_clk_in;
		case (state_ff)
			2'h0: if (go_in) begin
				status_low_n_out  <= 1'b0;
				status_high_n_out <= delay_in[0];
				in_status_out     <= 1'b1;
				state_ff          <= 2'h1;
			end
			2'h1: if (sys_fall) begin
				fall_cnt_ff <= (fall_cnt_ff == 4'h3) ? 4'h0 : fall_cnt_ff + 4'h1;
				if (fall_cnt_ff == 4'h3) begin
					{status_low_n_out, status_high_n_out} <= 2'h3;
					in_status_out <= 1'b0;
					state_ff      <= 2'h2;
				end
			end
			2'h2: if (sys_fall) begin
				fall_cnt_ff <= fall_cnt_ff + 4'h1;
				// Mode 1 sync pair, 2 async pair, 3 sync ready with its enable off
				if (fall_cnt_ff == delay_in) begin
					sync_n_out     <= ~mode_in[0];
					sync_en_n_out  <= (mode_in != 2'h1);
					async_n_out    <= (mode_in != 2'h2);
					async_en_n_out <= (mode_in != 2'h2);
					state_ff       <= 2'h3;
				end
			end
			default: if (!go_in) begin
				{async_n_out, async_en_n_out, sync_n_out, sync_en_n_out} <= 4'hF;
				fall_cnt_ff <= 4'h0;
				state_ff    <= 2'h0;
			end
		endcase
	end
endmodule : bus_side_model

/* clock_ready_pkg.sv */
`timescale 1ns/10ps
// Shared constants for the clock, ready and reset generator
package clock_ready_pkg;
	// Clock rate and synchroniser depth
	localparam int unsigned MCLK_HZ          = 50_000_000;
	localparam int unsigned PIN_SYNC_STAGES  = 2;
	localparam int unsigned ASYNC_SYNC_DEPTH = 2;
	// Strap coding: low picks the crystal, high the external frequency input
	localparam logic        SRC_CRYSTAL      = 1'b0;
	// Register offsets (byte addresses)
	localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
	// Control register fields
	localparam int unsigned CTRL_SW_RESET    = 0;
	localparam int unsigned CTRL_HOLD_PCLK   = 1;
	localparam int unsigned CTRL_WIDTH       = 2;
	localparam logic [1:0]  CTRL_RESET_VAL   = 2'h0;
	// Status register fields
	localparam int unsigned STS_SRC_SEL      = 0;
	localparam int unsigned STS_RESET        = 1;
	localparam int unsigned STS_PCLK         = 2;
	localparam int unsigned STS_READY        = 3;
	localparam int unsigned STS_ALIGNED      = 4;
	localparam int unsigned STS_WIDTH        = 5;
	// Flop values after reset
	localparam logic        PCLK_RESET_VAL   = 1'b1;
	localparam logic        RESET_OUT_INIT   = 1'b1;
endpackage : clock_ready_pkg

// Multi-stage flop chain with a hold enable; only the last stage is read outside
module sync_chain #(
	parameter int unsigned WIDTH  = 1,
	parameter int unsigned STAGES = 2
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             en_in,
	input  wire logic [WIDTH-1:0] rst_val_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	// Stage storage, index 0 meets the raw input
	logic [WIDTH-1:0] stage_ff [STAGES];

	// Less than two stages gives no metastability margin
	initial begin
		if (STAGES < 2) begin
			$error("sync_chain needs at least two stages");
		end
	end

	// Shift the chain; reset clears every stage to zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_ff[i] <= '0;
			end
		end else if (en_in) begin
			stage_ff[0] <= d_in;
			for (int i = 1; i < STAGES; i++) begin
				stage_ff[i] <= stage_ff[i-1];
			end
		end
	end

	// Idle level is folded in by xor so that reset can hold a constant zero
	assign q_out = stage_ff[STAGES-1] ^ rst_val_in;
endmodule : sync_chain

/* clock_ready_reset_generator.sv */
// Summary of operation
// - system clock runs twice processor clock rate
// - strap low picks crystal, high external input
// - crystal mode clock equals crystal frequency
// - peripheral clock is half rate, even duty
// - peripheral clock aligns after first bus cycle
// - status lines align clock and steer ready
// - async enable qualifies async ready input
// - async ready pins resolved before any use
// - sync enable selects sync ready input
// - qualified ready input ends current cycle
// - ready output only pulls low, open collector
// - reset output high from low reset request
// - ready held active while reset active
// - reset request synchronised before driving output
// - status low twice forces peripheral clock high
// - reset request sampled on clock falling edge
// - status low at falling edge floats ready
// - sync ready sampled when idle, pclk high
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
module clock_ready_reset_generator #(
	parameter int unsigned ASYNC_DEPTH = clock_ready_pkg::ASYNC_SYNC_DEPTH
) (
	// Clock, clock enable and reset
	input  wire logic        MCLK_IN,
	input  wire logic        CE_IN,
	input  wire logic        SYS_RST_IN,
	// Clock source pins and strap
	input  wire logic        CLK_SOURCE_SEL_IN,
	input  wire logic        CRYSTAL_PIN_A_IN,
	output logic             CRYSTAL_PIN_B_OUT,
	input  wire logic        EXTERNAL_FREQ_IN,
	// Bus status from the processor
	input  wire logic        BUS_STATUS_LOW_N_IN,
	input  wire logic        BUS_STATUS_HIGH_N_IN,
	// Ready sources from the address decoder
	input  wire logic        ASYNC_READY_N_IN,
	input  wire logic        ASYNC_READY_ENABLE_N_IN,
	input  wire logic        SYNC_READY_N_IN,
	input  wire logic        SYNC_READY_ENABLE_N_IN,
	// Reset request pin
	input  wire logic        SYS_INIT_REQUEST_N_IN,
	// Generated clocks and reset
	output logic             SYS_CLK_OUT,
	output logic             PERIPH_CLK_OUT,
	output logic             SYS_RESET_OUT,
	// Open-collector ready: value and active-low enable
	output logic             READY_N_OUT,
	output logic             READY_OE_N_OUT,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	// Deeper is fine, shallower would leave the resolve margin short
	initial begin
		if (ASYNC_DEPTH < 2) begin
			$error("ASYNC_DEPTH must be at least two");
		end
	end

	// Number of raw pins that pass the pin synchroniser
	localparam int unsigned NPIN = 10;
	// Idle levels of the pins: status and ready lines idle high, the reset request low
	localparam logic [NPIN-1:0] PIN_IDLE = 10'h3F0;

	// Raw pin bundle and its synchronised copy
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_q;
	// Synchronised pins by name
	wire             strap_q     = pin_q[0];
	wire             xtal_q      = pin_q[1];
	wire             efi_q       = pin_q[2];
	wire             sw_spare_q  = pin_q[3];
	wire             st_low_n_q  = pin_q[4];
	wire             st_high_n_q = pin_q[5];
	wire             async_ready_n_n_q    = pin_q[6];
	wire             async_ready_enable_n_n_q  = pin_q[7];
	wire             sync_ready_n_n_q    = pin_q[8];
	wire             sync_ready_enable_n_n_q  = pin_q[9];
	// Reset request kept apart so software can add to it
	logic            res_n_q;

	// Generated clock and event strobes
	logic            sys_clk_ff;
	logic            xtal_b_ff;
	wire             src_level;
	wire             fall_evt;
	// Peripheral clock and status history
	logic            pclk_ff;
	logic            nxt_pclk;
	logic            hist1_ff;
	logic            hist2_ff;
	logic            aligned_ff;
	wire             status_low;
	wire             force_high;
	// Reset output path
	logic            reset_ff;
	wire             reset_req;
	// Falling-edge resolver for the async ready pair
	logic [1:0]      async_res;
	wire             async_ok;
	wire             sync_ok;
	wire             sample_win;
	// Ready state: high means the output pulls low
	logic            ready_act_ff;
	logic            nxt_ready_act;
	// Software registers
	localparam int unsigned CLOCK_CTRL_W = clock_ready_pkg::CTRL_WIDTH;
	logic [CLOCK_CTRL_W-1:0] ctrl_ff;
	logic [31:0]     rdata_ff;
	logic [31:0]     status_word;
	wire             apb_setup;
	wire             apb_wr;
	wire             hit_ctrl;
	wire             hit_status;
	wire             hit_any;

	// True when either status line is active
	function automatic logic any_low(input logic a_n, input logic b_n);
		any_low = ~a_n | ~b_n;
	endfunction : any_low

	// Pins from outside the clock domain pass two flops before use
	assign pin_raw = {SYNC_READY_ENABLE_N_IN, SYNC_READY_N_IN,
		ASYNC_READY_ENABLE_N_IN, ASYNC_READY_N_IN,
		BUS_STATUS_HIGH_N_IN, BUS_STATUS_LOW_N_IN, SYS_INIT_REQUEST_N_IN,
		EXTERNAL_FREQ_IN, CRYSTAL_PIN_A_IN, CLK_SOURCE_SEL_IN};

	sync_chain #(
		.WIDTH  (NPIN),
		.STAGES (clock_ready_pkg::PIN_SYNC_STAGES)
	) pin_sync (
		.clk_in     (MCLK_IN),
		.rst_in     (SYS_RST_IN),
		.en_in      (CE_IN),
		.rst_val_in (PIN_IDLE),
		.d_in       (pin_raw ^ PIN_IDLE),
		.q_out      (pin_q)
	);

	// Slot 3 carries the reset request pin
	assign res_n_q = sw_spare_q;

	// Strap picks the source; crystal mode follows the crystal directly
	assign src_level = (strap_q == clock_ready_pkg::SRC_CRYSTAL) ? xtal_q : efi_q;
	// Falling edge of the generated clock, flagged in the cycle before it shows
	assign fall_evt  = CE_IN & sys_clk_ff & ~src_level;

	// Output clock is the chosen source, passed through at full rate
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			sys_clk_ff <= 1'b0;
			xtal_b_ff  <= 1'b1;
		end else if (CE_IN) begin
			sys_clk_ff <= src_level;
			xtal_b_ff  <= ~xtal_q;
		end
	end

	// Status lines sampled at falling edges drive all alignment
	assign status_low = any_low(st_low_n_q, st_high_n_q);
	assign force_high = hist1_ff & hist2_ff;

	// Peripheral clock halves the system clock unless status or the hold control bit forces it high
	always_comb begin
		if (force_high || ctrl_ff[clock_ready_pkg::CTRL_HOLD_PCLK]) begin
			nxt_pclk = 1'b1;
		end else begin
			nxt_pclk = ~pclk_ff;
		end
	end

	// Peripheral clock and two-deep status history
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			pclk_ff    <= clock_ready_pkg::PCLK_RESET_VAL;
			hist1_ff   <= 1'b0;
			hist2_ff   <= 1'b0;
			aligned_ff <= 1'b0;
		end else if (fall_evt) begin
			pclk_ff  <= nxt_pclk;
			hist1_ff <= status_low;
			hist2_ff <= hist1_ff;
			// Phase is trusted once a bus cycle has been seen after reset
			if (reset_ff) begin
				aligned_ff <= 1'b0;
			end else if (force_high) begin
				aligned_ff <= 1'b1;
			end
		end
	end

	// Software may add a reset request to the pin
	assign reset_req = ~res_n_q | ctrl_ff[clock_ready_pkg::CTRL_SW_RESET];

	// Reset output changes only at a falling edge, after pin resolve
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			reset_ff <= clock_ready_pkg::RESET_OUT_INIT;
		end else if (fall_evt) begin
			reset_ff <= reset_req;
		end
	end

	// Second resolver clocked on falling edges only
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			async_res <= 2'h0;
		end else if (fall_evt) begin
			async_res[0] <= ~async_ready_n_n_q & ~async_ready_enable_n_n_q;
			async_res[1] <= async_res[0];
		end
	end

	// Qualified sources; either pair alone is enough to set ready
	assign async_ok   = async_res[1];
	assign sync_ok    = ~sync_ready_n_n_q & ~sync_ready_enable_n_n_q;
	// Ready inputs are looked at only in the idle, pclk-high slot
	assign sample_win = ~status_low & pclk_ff;

	// Ready next state at each falling edge
	always_comb begin
		nxt_ready_act = ready_act_ff;
		if (reset_ff) begin
			nxt_ready_act = 1'b1;
		end else if (status_low) begin
			nxt_ready_act = 1'b0;
		end else if (sample_win) begin
			nxt_ready_act = async_ok | sync_ok;
		end
	end

	// Ready state register
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			ready_act_ff <= 1'b1;
		end else if (fall_evt) begin
			ready_act_ff <= nxt_ready_act;
		end
	end

	// APB decode; every access completes with no wait state
	assign apb_setup  = PSEL & ~PENABLE;
	assign apb_wr     = PSEL & PENABLE & PWRITE;
	assign hit_ctrl   = (PADDR == clock_ready_pkg::CTRL_OFFSET);
	assign hit_status = (PADDR == clock_ready_pkg::STATUS_OFFSET);
	assign hit_any    = hit_ctrl | hit_status;

	// Live view of the block's own state
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[clock_ready_pkg::STS_SRC_SEL] = strap_q;
		status_word[clock_ready_pkg::STS_RESET]   = reset_ff;
		status_word[clock_ready_pkg::STS_PCLK]    = pclk_ff;
		status_word[clock_ready_pkg::STS_READY]   = ready_act_ff;
		status_word[clock_ready_pkg::STS_ALIGNED] = aligned_ff;
	end

	// Control write and read capture; reads are sampled in the setup cycle
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			ctrl_ff  <= clock_ready_pkg::CTRL_RESET_VAL;
			rdata_ff <= 32'h0000_0000;
		end else if (CE_IN) begin
			if (apb_wr && hit_ctrl) begin
				ctrl_ff <= PWDATA[CLOCK_CTRL_W-1:0];
			end
			if (apb_setup && hit_ctrl) begin
				rdata_ff <= {{(32-CLOCK_CTRL_W){1'b0}}, ctrl_ff};
			end else if (apb_setup && hit_status) begin
				rdata_ff <= status_word;
			end else if (apb_setup) begin
				rdata_ff <= 32'h0000_0000;
			end
		end
	end

	// Bus answers; unmapped addresses return zero and an error
	assign PRDATA  = rdata_ff;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit_any;

	// Pin outputs; ready only ever pulls low, the pull-up makes high
	assign SYS_CLK_OUT       = sys_clk_ff;
	assign CRYSTAL_PIN_B_OUT = xtal_b_ff;
	assign PERIPH_CLK_OUT    = pclk_ff;
	assign SYS_RESET_OUT     = reset_ff;
	assign READY_N_OUT       = 1'b0;
	assign READY_OE_N_OUT    = ~ready_act_ff;

	// Generated clock tracks the chosen source one cycle late
	a_clk_source_sel: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		$past(CE_IN) |-> SYS_CLK_OUT == $past(src_level))
		else $error("system clock does not follow selected source");

	// Reset output follows the sampled request at the next falling edge
	a_reset_follows_req: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && reset_req |=> SYS_RESET_OUT)
		else $error("reset output missed an active request");

	// Reset output moves only at a falling edge
	a_reset_edge_only: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		!fall_evt |=> $stable(SYS_RESET_OUT))
		else $error("reset output changed away from a falling edge");

	// Ready is pulled low one falling edge after reset is seen
	a_ready_in_reset: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && SYS_RESET_OUT |=> !READY_OE_N_OUT && !READY_N_OUT)
		else $error("ready not held active during reset");

	// Status low at a falling edge floats ready
	a_status_floats: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && status_low && !SYS_RESET_OUT |=> READY_OE_N_OUT)
		else $error("ready not released at bus cycle start");

	// A resolved async ready terminates the cycle whatever the sync pair says
	a_async_wins: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && !SYS_RESET_OUT && sample_win && async_ok |=> !READY_OE_N_OUT)
		else $error("resolved async ready ignored");

	// Sync ready pair both low in the sample slot asserts ready
	a_sync_ready: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && !SYS_RESET_OUT && sample_win && !sync_ready_n_n_q && !sync_ready_enable_n_n_q
		|=> !READY_OE_N_OUT)
		else $error("sync ready not taken");

	// Neither source qualified in the slot drops ready
	a_ready_drops: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && !SYS_RESET_OUT && sample_win && !async_ok && !sync_ok
		|=> READY_OE_N_OUT)
		else $error("ready kept with no qualified source");

	// Two low status samples force the peripheral clock high
	a_pclk_forced: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && force_high |=> PERIPH_CLK_OUT)
		else $error("peripheral clock not forced high");

	// Otherwise, with the hold bit clear, the peripheral clock flips at every falling edge
	a_pclk_toggles: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt && !force_high && !ctrl_ff[clock_ready_pkg::CTRL_HOLD_PCLK]
		|=> PERIPH_CLK_OUT != $past(PERIPH_CLK_OUT))
		else $error("peripheral clock did not toggle");

	// Async pair reaches the decision two falling edges after resolve
	a_async_depth: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
		fall_evt |=> async_res[1] == $past(async_res[0]))
		else $error("async resolver stage skipped");
endmodule : clock_ready_reset_generator

/* clock_ready_reset_generator_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module clock_ready_reset_generator_bench;
	logic        mclk = 1'b0, rst = 1'b1, strap = 1'b0, req_n = 1'b1, go = 1'b0, ce = 1'b1;
	logic [1:0]  mode = 2'h1;
	logic [3:0]  delay = 4'h0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, d;
	logic        err;
	int          n_mismatch = 0, cmp_count = 0, hi, lo;
	wire logic   xa, xb, ef, stl, sth, ar, are, sr, sre, in_st, sclk, pclk, srst, rn, roe;
	wire logic   pready, pslverr;
	wire logic [31:0] prdata;
	wire logic   rdy_wire = roe ? 1'b1 : rn;  // Pull-up when nobody pulls low
	initial forever #10 mclk = ~mclk;
	bus_side_model model_u (.clk_in(mclk), .sys_clk_in(sclk), .go_in(go), .mode_in(mode),
		.delay_in(delay), .crystal_a_out(xa), .ext_freq_out(ef), .status_low_n_out(stl),
		.status_high_n_out(sth), .async_n_out(ar), .async_en_n_out(are), .sync_n_out(sr),
		.sync_en_n_out(sre), .in_status_out(in_st));
	clock_ready_reset_generator dut_u (.MCLK_IN(mclk), .CE_IN(ce), .SYS_RST_IN(rst),
		.CLK_SOURCE_SEL_IN(strap), .CRYSTAL_PIN_A_IN(xa), .CRYSTAL_PIN_B_OUT(xb),
		.EXTERNAL_FREQ_IN(ef), .BUS_STATUS_LOW_N_IN(stl), .BUS_STATUS_HIGH_N_IN(sth),
		.ASYNC_READY_N_IN(ar), .ASYNC_READY_ENABLE_N_IN(are), .SYNC_READY_N_IN(sr),
		.SYNC_READY_ENABLE_N_IN(sre), .SYS_INIT_REQUEST_N_IN(req_n), .SYS_CLK_OUT(sclk),
		.PERIPH_CLK_OUT(pclk), .SYS_RESET_OUT(srst), .READY_N_OUT(rn), .READY_OE_N_OUT(roe),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	// Output picked by number so one wait task serves every level
	function automatic logic pick(input int s);
		case (s)
			0: return sclk;
			1: return pclk;
			2: return srst;
			3: return rdy_wire;
			default: return xb;
		endcase
	endfunction : pick
	// Control bits that read back; upper bits read zero
	function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
		return v & ((32'h1 << clock_ready_pkg::CTRL_WIDTH) - 32'h1);
	endfunction : ctrl_exp
	task automatic wait_for(input string nm, input int s, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge mclk);
			n++;
		end
		`CHK(nm, v, pick(s))
	endtask : wait_for
	// Phase lengths in MCLK cycles, taken from one rising edge
	task automatic measure(input int s, output int h, output int l);
		h = 0;
		l = 0;
		wait_for("phase low", s, 1'b0, 100);
		wait_for("phase high", s, 1'b1, 100);
		while (pick(s) === 1'b1 && h < 100) begin
			@(posedge mclk);
			h++;
		end
		while (pick(s) === 1'b0 && l < 100) begin
			@(posedge mclk);
			l++;
		end
	endtask : measure
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A slave that never answers counts against the run
		if (pready !== 1'b1)
			n_mismatch++;
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One bus cycle; mode 3 is never answered
	task automatic bus_cycle(input logic [1:0] m, input logic [3:0] dl);
		mode  <= m;
		delay <= dl;
		go    <= 1'b1;
		// Ready may still be held from the last cycle, so wait for status first
		while (in_st !== 1'b1)
			@(posedge mclk);
		wait_for("ready floats", 3, 1'b1, 60);
		while (in_st !== 1'b0)
			@(posedge mclk);
		`CHK("pclk forced", 1'b1, pclk)
		`CHK("status floats", 1'b1, rdy_wire)
		if (m == 2'h3) begin
			repeat (250) @(posedge mclk);
			`CHK("ready refused", 1'b1, rdy_wire)
		end else
			wait_for("ready end", 3, 1'b0, 250);
		go <= 1'b0;
		@(posedge mclk);
	endtask : bus_cycle
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		results();
	end
	initial begin
		void'($urandom(32'h3fb293aa));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		`CHK("ready in reset", 1'b0, rdy_wire)
		`CHK("open collector", 1'b0, rn)
		wait_for("reset ends", 2, 1'b0, 40);
		apb(1'b0, clock_ready_pkg::CTRL_OFFSET, 32'h0, rd, err);
		`CHK("ctrl reset", 32'h0, rd)
		$display("test reset done");
		// Crystal then external source: system clock follows the strap
		measure(0, hi, lo);
		`CHK("crystal high", 5, hi)
		`CHK("crystal low", 5, lo)
		measure(1, hi, lo);
		`CHK("pclk high", 10, hi)
		`CHK("pclk low", 10, lo)
		// Crystal feedback is the inverse of the level the clock shows
		wait_for("feedback low", 4, 1'b0, 20);
		`CHK("feedback inverse", 1'b1, sclk)
		strap <= 1'b1;
		repeat (40) @(posedge mclk);
		measure(0, hi, lo);
		`CHK("external period", 12, hi + lo)
		apb(1'b0, clock_ready_pkg::STATUS_OFFSET, 32'h0, rd, err);
		`CHK("strap status", 1'b1, rd[clock_ready_pkg::STS_SRC_SEL])
		strap <= 1'b0;
		repeat (40) @(posedge mclk);
		$display("test clocks done");
		// Corner delays, the refused pair, then random cycles
		bus_cycle(2'h1, 4'h0);
		apb(1'b0, clock_ready_pkg::STATUS_OFFSET, 32'h0, rd, err);
		`CHK("aligned", 1'b1, rd[clock_ready_pkg::STS_ALIGNED])
		bus_cycle(2'h2, 4'hF);
		bus_cycle(2'h3, 4'h1);
		bus_cycle(2'h2, 4'h0);
		repeat (6) bus_cycle(2'($urandom_range(2, 1)), 4'($urandom_range(15, 0)));
		$display("test ready done");
		// Pin reset request
		req_n <= 1'b0;
		wait_for("reset rises", 2, 1'b1, 36);
		wait_for("ready forced", 3, 1'b0, 24);
		req_n <= 1'b1;
		wait_for("reset falls", 2, 1'b0, 36);
		$display("test pin reset done");
		// Register reset, random control values, unmapped access
		apb(1'b1, clock_ready_pkg::CTRL_OFFSET, 32'h1, rd, err);
		wait_for("soft reset", 2, 1'b1, 36);
		apb(1'b1, clock_ready_pkg::CTRL_OFFSET, 32'h0, rd, err);
		wait_for("soft release", 2, 1'b0, 36);
		repeat (4) begin
			d = $urandom() & 32'hFFFF_FFFE;
			apb(1'b1, clock_ready_pkg::CTRL_OFFSET, d, rd, err);
			apb(1'b0, clock_ready_pkg::CTRL_OFFSET, 32'h0, rd, err);
			`CHK("ctrl readback", ctrl_exp(d), rd)
		end
		apb(1'b0, 8'h08, 32'h0, rd, err);
		`CHK("unmapped error", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		apb(1'b1, clock_ready_pkg::CTRL_OFFSET, 32'h0, rd, err);
		$display("test registers done");
		// Clock enable low freezes the clocks and the ready state
		ce <= 1'b0;
		@(posedge mclk);
		lo = {29'h0, pclk, sclk, roe};
		repeat (30) @(posedge mclk);
		`CHK("enable freeze", lo, {29'h0, pclk, sclk, roe})
		ce <= 1'b1;
		$display("test clock enable done");
		results();
	end
endmodule : clock_ready_reset_generator_bench
